// ===== rtl/tcspwm_pkg.sv
// Purpose: constants for the three channel sub-cycle modulator
// Assumes: 8-bit register port, 200 MHz system clock
// Notes:   register indices are byte addresses on the plain port
package tcspwm_pkg;
	localparam int unsigned TCS_AW = 3;
	localparam logic [2:0] TCS_ADDR_CTRL  = 3'h0;
	localparam logic [2:0] TCS_ADDR_DUTY0 = 3'h1;
	localparam logic [2:0] TCS_ADDR_DUTY1 = 3'h2;
	localparam logic [2:0] TCS_ADDR_DUTY2 = 3'h3;
	localparam logic [2:0] TCS_ADDR_PDATA = 3'h4;
	localparam logic [2:0] TCS_ADDR_PDIR  = 3'h5;
	localparam logic [2:0] TCS_ADDR_PIN   = 3'h6;
	localparam int unsigned TCS_BIT_SCHEME = 7;
	localparam logic [7:0] TCS_CTRL_RESET  = 8'h00;
	localparam logic [7:0] TCS_CTRL_MASK   = 8'h87;
	localparam logic [7:0] TCS_DUTY_RESET  = 8'h00;
	localparam logic [2:0] TCS_PDATA_RESET = 3'h0;
	localparam logic [2:0] TCS_PDIR_RESET  = 3'h7;
	localparam logic [7:0] TCS_SUB4_LEN    = 8'h40;
	localparam logic [7:0] TCS_SUB2_LEN    = 8'h80;
endpackage

// ===== rtl/tcspwm_sync.sv
// Purpose: two flop synchroniser for the pin read-back
// Assumes: asynchronous pin levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module tcspwm_sync
	import tcspwm_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	// data
	input  wire logic [2:0] async_in,
	output logic      [2:0] sync_out
);
	typedef struct packed
	{
		logic [2:0] s1;
		logic [2:0] s2;
	} tcspwm_sync_st_t;

	tcspwm_sync_st_t st_q;
	tcspwm_sync_st_t st_d;

	always_comb
	begin
		st_d    = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign sync_out = st_q.s2;
endmodule

// ===== rtl/tcspwm_chan.sv
// Purpose: one modulator channel, compares position with the split duty value
// Assumes: shared cycle counter from the top
// Notes:   duty is latched at the start of each full cycle
`timescale 1ns/10ps
module tcspwm_chan
	import tcspwm_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	// control
	input  wire logic [7:0] duty_value,
	input  wire logic       scheme,
	input  wire logic [7:0] cyc_cnt,
	// waveform
	output logic            wave
);
	typedef struct packed
	{
		logic [7:0] duty;
		logic       sch;
		logic       wave;
	} tcspwm_chan_st_t;

	tcspwm_chan_st_t st_q;
	tcspwm_chan_st_t st_d;

	// high time of the sub-cycle that contains position pos
	function automatic logic [7:0] high_len(input logic [7:0] d, input logic sch,
		input logic [7:0] pos);
		logic [7:0] coarse_duty;
		logic [1:0] extra_pulse_count;
		logic [1:0] idx;
		coarse_duty       = '0;
		extra_pulse_count = '0;
		idx               = '0;
		if (sch)
		begin
			coarse_duty       = {1'b0, d[7:1]};
			extra_pulse_count = {1'b0, d[0]};
			idx               = {1'b0, pos[7]};
		end
		else
		begin
			coarse_duty       = {2'b00, d[7:2]};
			extra_pulse_count = d[1:0];
			idx               = pos[7:6];
		end
		return (idx < extra_pulse_count) ? 8'(coarse_duty + 8'h01) : coarse_duty;
	endfunction

	logic [7:0] off_pos;
	logic [7:0] duty_use;
	logic       sch_use;

	always_comb
	begin
		st_d = st_q;
		duty_use = (cyc_cnt == 8'h00) ? duty_value : st_q.duty;
		// scheme is latched with the duty so one cycle never mixes two splits
		sch_use = (cyc_cnt == 8'h00) ? scheme : st_q.sch;
		off_pos = sch_use ? {1'b0, cyc_cnt[6:0]} : {2'b00, cyc_cnt[5:0]};
		if (cyc_cnt == 8'h00)
		begin
			st_d.duty = duty_value;
			st_d.sch  = scheme;
		end
		// high from the sub-cycle start for its computed length
		st_d.wave = off_pos < high_len(duty_use, sch_use, cyc_cnt);
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign wave = st_q.wave;
endmodule

// ===== rtl/tcspwm_top.sv
// Purpose: three channel 8-bit modulator with shared port pins
// Assumes: register port strobes are one cycle, never together
// Notes:   wave lags the counter by one cycle, pin outputs by two cycles
`timescale 1ns/10ps
// Operation
// - three channels, each with its own writable 8-bit duty register
// - counters run from the system clock only
// - full cycle is 256 clocks, overall duty equals value over 256
// - scheme bit 0 picks four sub-cycles, 1 picks two sub-cycles
// - control bits 2..0 enable channels 2..0
// - four-scheme sub-cycles 0..3 of 64 clocks each
// - four-scheme coarse duty is bits 7..2, extra count bits 1..0
// - four-scheme sub-cycle i gets coarse plus one while i below extra
// - two-scheme sub-cycles 0..1 of 128 clocks each
// - two-scheme coarse duty is bits 7..1, extra count bit 0
// - two-scheme sub-cycle i gets coarse plus one while i below extra
// - hardware splits the duty by itself; software only writes it
// - data bit zero forces the pin low
// - pin set as input stays an ordinary input
module tcspwm_top
	import tcspwm_pkg::*;
(
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rst_b,
	// register port
	input  wire logic [TCS_AW-1:0] reg_addr,
	input  wire logic [7:0]    reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [7:0]    reg_rdata,
	// shared pins: channel 0..2
	input  wire logic [2:0]    shared_pin_in,
	output logic      [2:0]    shared_pin_out,
	output logic      [2:0]    shared_pin_oe
);
	typedef struct packed
	{
		logic [7:0] modulator_control;
		logic [7:0] duty_value_ch0;
		logic [7:0] duty_value_ch1;
		logic [7:0] duty_value_ch2;
		logic [2:0] port_c_output_latch;
		logic [2:0] port_c_dir;
		logic [7:0] cyc_cnt;
		logic [7:0] rdata;
		logic [2:0] pin_out;
		logic [2:0] pin_oe;
	} tcspwm_st_t;

	tcspwm_st_t st_q;
	tcspwm_st_t st_d;
	logic [2:0] wave;
	logic [2:0] pin_sync;
	logic [2:0] chan_en;

	tcspwm_sync u_sync
	(
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.async_in (shared_pin_in),
		.sync_out (pin_sync)
	);

	tcspwm_chan u_ch0
	(
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.duty_value (st_q.duty_value_ch0),
		.scheme     (st_q.modulator_control[TCS_BIT_SCHEME]),
		.cyc_cnt    (st_q.cyc_cnt),
		.wave       (wave[0])
	);

	tcspwm_chan u_ch1
	(
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.duty_value (st_q.duty_value_ch1),
		.scheme     (st_q.modulator_control[TCS_BIT_SCHEME]),
		.cyc_cnt    (st_q.cyc_cnt),
		.wave       (wave[1])
	);

	tcspwm_chan u_ch2
	(
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.duty_value (st_q.duty_value_ch2),
		.scheme     (st_q.modulator_control[TCS_BIT_SCHEME]),
		.cyc_cnt    (st_q.cyc_cnt),
		.wave       (wave[2])
	);

	assign chan_en = st_q.modulator_control[2:0];

	always_comb
	begin
		st_d         = st_q;
		// free running position within the 256 clock cycle
		st_d.cyc_cnt = 8'(st_q.cyc_cnt + 8'h01);
		// register writes; software writes the whole duty value, never its split
		if (reg_wr)
		begin
			if (reg_addr == TCS_ADDR_CTRL)
				st_d.modulator_control = reg_wdata & TCS_CTRL_MASK;
			else if (reg_addr == TCS_ADDR_DUTY0)
				st_d.duty_value_ch0 = reg_wdata;
			else if (reg_addr == TCS_ADDR_DUTY1)
				st_d.duty_value_ch1 = reg_wdata;
			else if (reg_addr == TCS_ADDR_DUTY2)
				st_d.duty_value_ch2 = reg_wdata;
			else if (reg_addr == TCS_ADDR_PDATA)
				st_d.port_c_output_latch = reg_wdata[2:0];
			else if (reg_addr == TCS_ADDR_PDIR)
				st_d.port_c_dir = reg_wdata[2:0];
		end
		st_d.rdata = 8'h00;
		if (reg_rd)
		begin
			if (reg_addr == TCS_ADDR_CTRL)
				st_d.rdata = st_q.modulator_control;
			else if (reg_addr == TCS_ADDR_DUTY0)
				st_d.rdata = st_q.duty_value_ch0;
			else if (reg_addr == TCS_ADDR_DUTY1)
				st_d.rdata = st_q.duty_value_ch1;
			else if (reg_addr == TCS_ADDR_DUTY2)
				st_d.rdata = st_q.duty_value_ch2;
			else if (reg_addr == TCS_ADDR_PDATA)
				st_d.rdata = {5'h00, st_q.port_c_output_latch};
			else if (reg_addr == TCS_ADDR_PDIR)
				st_d.rdata = {5'h00, st_q.port_c_dir};
			else if (reg_addr == TCS_ADDR_PIN)
				st_d.rdata = {5'h00, pin_sync};
		end
		for (int i = 0; i < 3; i++)
		begin
			// direction bit 1 leaves the pin an input
			st_d.pin_oe[i] = ~st_q.port_c_dir[i];
			if (chan_en[i])
				st_d.pin_out[i] = st_q.port_c_output_latch[i] & wave[i];
			else
				st_d.pin_out[i] = st_q.port_c_output_latch[i];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_q                     <= '0;
			st_q.modulator_control   <= TCS_CTRL_RESET;
			st_q.duty_value_ch0      <= TCS_DUTY_RESET;
			st_q.duty_value_ch1      <= TCS_DUTY_RESET;
			st_q.duty_value_ch2      <= TCS_DUTY_RESET;
			st_q.port_c_output_latch <= TCS_PDATA_RESET;
			st_q.port_c_dir          <= TCS_PDIR_RESET;
			st_q.pin_oe              <= 3'h0;
		end
		else
			st_q <= st_d;
	end

	assign reg_rdata      = st_q.rdata;
	assign shared_pin_out = st_q.pin_out;
	assign shared_pin_oe  = st_q.pin_oe;

	// helper: count of high samples of channel 0 wave in a full cycle
	logic [8:0] hi_cnt_q;
	logic [7:0] duty0_cyc_q;
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hi_cnt_q    <= 9'h000;
			duty0_cyc_q <= 8'h00;
		end
		else if (st_q.cyc_cnt == 8'h01)
		begin
			hi_cnt_q    <= {8'h00, wave[0]};
			duty0_cyc_q <= u_ch0.st_q.duty;
		end
		else
			hi_cnt_q <= 9'(hi_cnt_q + {8'h00, wave[0]});
	end

	// set once a whole cycle has been counted since reset
	logic cyc_seen_q;
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			cyc_seen_q <= 1'b0;
		else if (st_q.cyc_cnt == 8'hFF)
			cyc_seen_q <= 1'b1;
	end

	// helper: channel 1 high clocks per sub-cycle against the split rule
	logic       sub_begin;
	logic [7:0] sub_want;
	logic       sub_start_q;
	logic [7:0] sub_hi_q;
	logic [7:0] sub_nxt_q;
	logic [7:0] sub_cur_q;

	always_comb
	begin
		sub_begin = 1'b0;
		sub_want  = 8'h00;
		if (u_ch1.sch_use)
		begin
			sub_begin = st_q.cyc_cnt[6:0] == 7'h00;
			sub_want  = {1'b0, u_ch1.duty_use[7:1]};
			if (st_q.cyc_cnt[7] < u_ch1.duty_use[0])
				sub_want = 8'(sub_want + 8'h01);
		end
		else
		begin
			sub_begin = st_q.cyc_cnt[5:0] == 6'h00;
			sub_want  = {2'b00, u_ch1.duty_use[7:2]};
			if (st_q.cyc_cnt[7:6] < u_ch1.duty_use[1:0])
				sub_want = 8'(sub_want + 8'h01);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sub_start_q <= 1'b0;
			sub_hi_q    <= 8'h00;
			sub_nxt_q   <= 8'h00;
			sub_cur_q   <= 8'h00;
		end
		else
		begin
			sub_start_q <= sub_begin;
			if (sub_begin)
				sub_nxt_q <= sub_want;
			if (sub_start_q)
			begin
				sub_hi_q  <= {7'h00, wave[1]};
				sub_cur_q <= sub_nxt_q;
			end
			else
				sub_hi_q <= 8'(sub_hi_q + {7'h00, wave[1]});
		end
	end

	a_cycle_duty_total: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_q.cyc_cnt == 8'h01 && cyc_seen_q
			&& $past(duty0_cyc_q) == duty0_cyc_q)
			|-> hi_cnt_q == {1'b0, duty0_cyc_q})
		else $error("channel 0 high count differs from duty");
	a_pin_gate_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$past(st_q.port_c_output_latch[1] == 1'b0) |-> !shared_pin_out[1])
		else $error("pin driven high while data bit clear");
	a_dir_input_oe: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$past(st_q.port_c_dir[2]) |-> !shared_pin_oe[2])
		else $error("pin driven while set as input");
	a_counter_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
		st_q.cyc_cnt == 8'hFF |=> st_q.cyc_cnt == 8'h00)
		else $error("cycle counter did not wrap");
	a_duty_held: assert property (@(posedge sys_clk) disable iff (!rst_b)
		st_q.cyc_cnt != 8'h00 |=> $stable(u_ch0.st_q.duty))
		else $error("duty changed mid cycle");
	a_duty_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
		st_q.cyc_cnt == 8'h00 |=> u_ch1.st_q.duty == $past(st_q.duty_value_ch1))
		else $error("duty not loaded at cycle start");
	a_sub_start_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_q.cyc_cnt[5:0] == 6'h00 && !u_ch0.sch_use
			&& u_ch0.duty_use[7:2] != 6'h00) |=> wave[0])
		else $error("sub-cycle did not start high");
	a_zero_duty_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(u_ch2.duty_use == 8'h00) |=> !wave[2])
		else $error("zero duty produced a pulse");
	a_disabled_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!chan_en[0] |=> shared_pin_out[0] == $past(st_q.port_c_output_latch[0]))
		else $error("disabled channel not plain port");
	a_ctrl_reserved: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_q.modulator_control & ~TCS_CTRL_MASK) == 8'h00)
		else $error("reserved control bits set");

	c_scheme_two: cover property (@(posedge sys_clk) disable iff (!rst_b)
		st_q.modulator_control[7] && wave[0]);
	c_scheme_four: cover property (@(posedge sys_clk) disable iff (!rst_b)
		!st_q.modulator_control[7] && wave[1]);
	a_pin_follow_wave: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(chan_en[0] && st_q.port_c_output_latch[0]) |=> shared_pin_out[0] == $past(wave[0]))
		else $error("enabled pin does not follow its wave");
	a_oe_when_output: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!st_q.port_c_dir[0] |=> shared_pin_oe[0])
		else $error("output pin not driven");
	a_sub_end_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_q.cyc_cnt[5:0] == 6'h3F && !u_ch0.sch_use
			&& u_ch0.duty_use[7:2] != 6'h3F) |=> !wave[0])
		else $error("sub-cycle still high at its last clock");
	a_sub_start_two: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_q.cyc_cnt[6:0] == 7'h00 && u_ch1.sch_use
			&& u_ch1.duty_use[7:1] != 7'h00) |=> wave[1])
		else $error("two-scheme sub-cycle did not start high");
	a_sub_high_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
		sub_start_q |-> sub_hi_q == sub_cur_q)
		else $error("sub-cycle high count differs from split duty");

	c_pin_driven: cover property (@(posedge sys_clk) disable iff (!rst_b)
		shared_pin_oe[0] && shared_pin_out[0]);
	c_pin_gated: cover property (@(posedge sys_clk) disable iff (!rst_b)
		chan_en[1] && shared_pin_oe[1] && !st_q.port_c_output_latch[1]);
	c_pin_input: cover property (@(posedge sys_clk) disable iff (!rst_b)
		!shared_pin_oe[2] && !pin_sync[2]);
endmodule

// ===== sim/tcspwm_load.sv
// Purpose: external load on the three shared pins
// Assumes: each pin has a pull-high when nobody drives it
// Notes:   hold_en lets the bench drive a released pin
`timescale 1ns/10ps
module tcspwm_load
(
	// from the block
	input  wire logic [2:0] pin_out,
	input  wire logic [2:0] pin_oe,
	// bench control
	input  wire logic [2:0] hold_en,
	input  wire logic [2:0] hold_lvl,
	// resolved pin level
	output logic      [2:0] pin_lvl
);
	// a released pin rises through its pull-high
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			pin_lvl[i] = pin_oe[i] ? pin_out[i] : (hold_en[i] ? hold_lvl[i] : 1'b1);
	end
endmodule

// ===== sim/tcspwm_top_tb.sv
// Purpose: self-checking bench for the three channel modulator
// Assumes: pins reach the bench through the load model
// Notes:   waveforms are judged over one full 256 clock cycle
`timescale 1ns/10ps
module tcspwm_top_tb
	import tcspwm_pkg::*;
;
	logic              sys_clk   = 1'b0;
	logic              rst_b     = 1'b0;
	logic [TCS_AW-1:0] reg_addr  = 3'h0;
	logic [7:0]        reg_wdata = 8'h00;
	logic              reg_wr    = 1'b0;
	logic              reg_rd    = 1'b0;
	logic [7:0]        reg_rdata;
	logic [2:0]        pin_lvl;
	logic [2:0]        pin_out;
	logic [2:0]        pin_oe;
	logic [2:0]        hold_en   = 3'h0;
	logic [2:0]        hold_lvl  = 3'h0;
	logic [2:0]        smp [512];
	logic [7:0]        duty [3]  = '{8'h65, 8'h9E, 8'h4B};
	int                miscompares = 0;
	int                cmp_count   = 0;

	always #2.5 sys_clk = ~sys_clk;

	tcspwm_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.shared_pin_in(pin_lvl), .shared_pin_out(pin_out), .shared_pin_oe(pin_oe));
	tcspwm_load load_u (.pin_out(pin_out), .pin_oe(pin_oe), .hold_en(hold_en),
		.hold_lvl(hold_lvl), .pin_lvl(pin_lvl));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1 chk({24'h0, reg_rdata & m}, {24'h0, e});
		@(posedge sys_clk);
		#1 chk({24'h0, reg_rdata}, 32'h0);
	endtask

	task automatic grab(input int wait_n);
		repeat (wait_n) @(posedge sys_clk);
		for (int i = 0; i < 512; i++)
		begin
			@(posedge sys_clk);
			#1 smp[i] = pin_lvl;
		end
	endtask

	// total high over 256 clocks, then pulse structure from the first rise
	task automatic ana(input int ch, input logic [7:0] d, input logic sch, input int tot_e,
		input logic deep);
		int s = 1;
		int tot = 0;
		int rises = 0;
		int longs = 0;
		int odd = 0;
		int last = -1;
		int len;
		int c = sch ? d[7:1] : d[7:2];
		int x = sch ? d[0] : d[1:0];
		int sl = sch ? 128 : 64;
		for (int i = 0; i < 256; i++)
			tot += smp[i][ch];
		chk(tot, tot_e);
		if (deep)
		begin
			while (s < 256 && !(smp[s][ch] && !smp[s-1][ch]))
				s++;
			for (int i = s; i < s + 256; i++)
				if (smp[i][ch] && (i == s || !smp[i-1][ch]))
				begin
					len = 0;
					while (i + len < 512 && smp[i+len][ch])
						len++;
					rises++;
					longs += (len == c + 1);
					odd += (len != c && len != c + 1) || (last >= 0 && i - last != sl);
					last = i;
				end
			chk(rises, 256 / sl);
			chk(longs, x);
			chk(odd, 0);
		end
	endtask

	initial
	begin
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(TCS_ADDR_CTRL, 8'hFF, 8'h00);
		for (int ch = 0; ch < 3; ch++)
			rd(3'(TCS_ADDR_DUTY0 + ch), 8'hFF, 8'h00);
		rd(TCS_ADDR_PDIR, 8'h07, 8'h07);
		rd(TCS_ADDR_PIN, 8'h07, 8'h07);
		rd(3'h7, 8'hFF, 8'h00);
		wr(TCS_ADDR_CTRL, 8'hFF);
		rd(TCS_ADDR_CTRL, 8'hFF, 8'h87);
		// bring-up order: control, direction, duty, then data bit
		wr(TCS_ADDR_CTRL, 8'h07);
		wr(TCS_ADDR_PDIR, 8'h00);
		for (int ch = 0; ch < 3; ch++)
			wr(3'(TCS_ADDR_DUTY0 + ch), duty[ch]);
		wr(TCS_ADDR_PDATA, 8'h07);
		rd(TCS_ADDR_DUTY1, 8'hFF, 8'h9E);
		for (int m = 0; m < 2; m++)
		begin
			if (m == 1)
				wr(TCS_ADDR_CTRL, 8'h87);
			grab(512);
			for (int ch = 0; ch < 3; ch++)
				ana(ch, duty[ch], m[0], duty[ch], 1'b1);
		end
		wr(TCS_ADDR_PDATA, 8'h05);
		wr(TCS_ADDR_CTRL, 8'h83);
		grab(8);
		ana(0, duty[0], 1'b1, duty[0], 1'b1);
		ana(1, duty[1], 1'b1, 0, 1'b0);
		ana(2, duty[2], 1'b1, 256, 1'b0);
		wr(TCS_ADDR_PDIR, 8'h04);
		hold_en  <= 3'h4;
		hold_lvl <= 3'h0;
		repeat (4) @(posedge sys_clk);
		#1 chk({31'h0, pin_oe[2]}, 32'h0);
		rd(TCS_ADDR_PIN, 8'h04, 8'h00);
		hold_lvl <= 3'h4;
		repeat (4) @(posedge sys_clk);
		rd(TCS_ADDR_PIN, 8'h04, 8'h04);
		final_report;
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		final_report;
	end
endmodule
